// >>> rtl/gld_display_top.sv
// gauge led display control, magnitude filter and soft reset registers
`timescale 1ns/100ps
module gld_display_top
	import gld_pkg::*;
#(
	parameter int MOD_CYCLES = GLD_MOD_CYCLES,
	parameter int BLINK_HALF_CYCLES = GLD_BLINK_HALF_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic showLevelRequestN,
	input wire logic showLevelFloat,
	input wire logic selfDischargeOptionPin,
	input wire logic firstEmptyFlag,
	input wire logic finalEmptyFlag,
	input wire logic signed [15:0] senseLevelUv,
	input wire logic [3:0] tempCode,
	input wire logic chargeTick,
	input wire logic dischargeTick,
	input wire logic selfDischargeTick,
	input wire logic [7:0] programmedFullCount,
	output logic [4:0] ledDriveLines,
	output logic [7:0] learnedFullCapacity,
	output logic [7:0] availableChargeCount,
	output logic [7:0] availableChargeLow,
	output logic [7:0] capacityInaccurateCount,
	output logic validDischargeQualifier,
	output logic learnStaleFlag,
	output logic batteryReplacedFlag,
	output logic validCharge,
	output logic validDischarge
);
	// pin synchronisers
	logic [2:0] pinMeta;
	logic [2:0] pinSync;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pinMeta <= 3'h1;
			pinSync <= 3'h1;
		end
		else
		begin
			pinMeta <= {selfDischargeOptionPin, showLevelFloat,
				showLevelRequestN};
			pinSync <= pinMeta;
		end
	end
	logic reqHigh;
	logic reqFloat;
	logic selfDisOff;
	assign reqHigh = pinSync[0];
	assign reqFloat = pinSync[1];
	assign selfDisOff = pinSync[2];
	// register file and gauge state
	logic [7:0] filterSetting;
	logic [7:0] next_filterSetting;
	logic [7:0] swReset;
	logic [7:0] next_swReset;
	logic initLoad;
	logic softReset;
	logic [7:0] next_lfc;
	logic [7:0] next_nach;
	logic [7:0] next_available_charge_low;
	logic [7:0] next_cic;
	logic next_vdq;
	logic next_stale;
	logic next_repl;
	logic [7:0] next_rdData;
	logic [15:0] nacWord;
	logic [15:0] nacStep;

	assign softReset = regWrite && regAddr == GLD_ADDR_SWRST &&
		swReset == GLD_SWRST_IDLE && regWrData == GLD_SWRST_FIRE;
	assign nacWord = {availableChargeCount, availableChargeLow};
	always_comb
	begin
		nacStep = nacWord;
		if (chargeTick && !dischargeTick)
		begin
			if (availableChargeCount < learnedFullCapacity)
				nacStep = nacWord + 16'h0001;
		end
		else if (!chargeTick &&
			(dischargeTick || (selfDischargeTick && !selfDisOff)))
		begin
			if (nacWord != 16'h0000)
				nacStep = nacWord - 16'h0001;
		end
		next_filterSetting = filterSetting;
		next_swReset = swReset;
		if (regWrite && regAddr == GLD_ADDR_FILTER)
			next_filterSetting = regWrData;
		if (regWrite && regAddr == GLD_ADDR_SWRST)
			next_swReset = regWrData;
		next_lfc = learnedFullCapacity;
		{next_nach, next_available_charge_low} = nacStep;
		if (regWrite && regAddr == GLD_ADDR_NACH)
			next_nach = regWrData;
		next_cic = capacityInaccurateCount;
		next_vdq = validDischargeQualifier;
		next_stale = learnStaleFlag;
		next_repl = batteryReplacedFlag;
		if (initLoad || softReset)
		begin
			next_filterSetting = GLD_FILTER_RESET;
			next_swReset = GLD_SWRST_IDLE;
			next_lfc = programmedFullCount;
			next_nach = GLD_NAC_RESET;
			next_available_charge_low = GLD_NAC_RESET;
			next_cic = GLD_CIC_RESET;
			next_vdq = GLD_VDQ_RESET;
			next_stale = GLD_STALE_RESET;
			next_repl = GLD_REPL_RESET;
		end
		next_rdData = regRdData;
		if (regRead)
		begin
			unique case (regAddr)
				GLD_ADDR_NACH: next_rdData = availableChargeCount;
				GLD_ADDR_AVAILABLE_CHARGE_LOW: next_rdData = availableChargeLow;
				GLD_ADDR_LFC: next_rdData = learnedFullCapacity;
				GLD_ADDR_CIC: next_rdData = capacityInaccurateCount;
				GLD_ADDR_FILTER: next_rdData = filterSetting;
				GLD_ADDR_SWRST: next_rdData = swReset;
				default: next_rdData = 8'h00;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			initLoad <= 1'b1;
			filterSetting <= GLD_FILTER_RESET;
			swReset <= GLD_SWRST_IDLE;
			learnedFullCapacity <= 8'h00;
			availableChargeCount <= GLD_NAC_RESET;
			availableChargeLow <= GLD_NAC_RESET;
			capacityInaccurateCount <= GLD_CIC_RESET;
			validDischargeQualifier <= GLD_VDQ_RESET;
			learnStaleFlag <= GLD_STALE_RESET;
			batteryReplacedFlag <= GLD_REPL_RESET;
			regRdData <= 8'h00;
		end
		else
		begin
			initLoad <= 1'b0;
			filterSetting <= next_filterSetting;
			swReset <= next_swReset;
			learnedFullCapacity <= next_lfc;
			availableChargeCount <= next_nach;
			availableChargeLow <= next_available_charge_low;
			capacityInaccurateCount <= next_cic;
			validDischargeQualifier <= next_vdq;
			learnStaleFlag <= next_stale;
			batteryReplacedFlag <= next_repl;
			regRdData <= next_rdData;
		end
	end
	// magnitude filter comparison
	logic signed [16:0] senseExt;
	logic signed [16:0] chargeLimit;
	logic signed [16:0] dischargeLimit;
	assign senseExt = {senseLevelUv[15], senseLevelUv};
	assign chargeLimit = $signed({13'h0000,
		filterSetting[GLD_FLT_CHG_LSB +: 4]}) * GLD_THR_STEP_UV;
	assign dischargeLimit = -($signed({13'h0000,
		filterSetting[GLD_FLT_DSG_LSB +: 4]}) * GLD_THR_STEP_UV);
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			validCharge <= 1'b0;
			validDischarge <= 1'b0;
		end
		else
		begin
			validCharge <= senseExt >= chargeLimit;
			validDischarge <= senseExt <= dischargeLimit;
		end
	end

	// temperature derating with hysteresis
	gld_derate_t derate;
	gld_derate_t next_derate;
	always_comb
	begin
		next_derate = derate;
		unique case (derate)
			GLD_DR_FULL:
				if (tempCode <= GLD_TC_COLD_MAX)
					next_derate = GLD_DR_COLD;
				else if (tempCode <= GLD_TC_COOL_MAX)
					next_derate = GLD_DR_COOL;
			GLD_DR_COOL:
				if (tempCode <= GLD_TC_COLD_MAX)
					next_derate = GLD_DR_COLD;
				else if (tempCode >= GLD_TC_COOL_EXIT)
					next_derate = GLD_DR_FULL;
			GLD_DR_COLD:
				if (tempCode >= GLD_TC_COOL_EXIT)
					next_derate = GLD_DR_FULL;
				else if (tempCode >= GLD_TC_COLD_EXIT)
					next_derate = GLD_DR_COOL;
			default: next_derate = GLD_DR_FULL;
		endcase
	end
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			derate <= GLD_DR_FULL;
		else
			derate <= next_derate;
	end
	// derated level only feeds the display
	logic [7:0] shownCharge;
	always_comb
	begin
		unique case (derate)
			GLD_DR_COOL: shownCharge = availableChargeCount -
				(availableChargeCount >> 2);
			GLD_DR_COLD: shownCharge = availableChargeCount >> 1;
			default: shownCharge = availableChargeCount;
		endcase
	end

	// modulation timing
	gld_mod_if modIf ();
	gld_led_modulator #(
		.MOD_CYCLES(MOD_CYCLES),
		.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
	) u_modulator (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.modIf(modIf)
	);

	logic displayOn;
	assign displayOn = !finalEmptyFlag &&
		((!reqHigh && !reqFloat) ||
		(reqFloat && (senseExt < GLD_SHOW_LEVEL_REQUEST_N_DSG_UV || validCharge)));

	logic [4:0] next_leds;
	logic [10:0] shownTimes5;
	assign shownTimes5 = 11'(shownCharge) * 11'h005;
	genvar seg;
	generate
		for (seg = 0; seg < GLD_NUM_SEG; seg++)
		begin : g_seg
			logic lit;
			logic bankOn;
			logic blinkOk;
			assign lit = shownCharge != 8'h00 &&
				shownTimes5 >= 11'(learnedFullCapacity) * 11'(seg + 1);
			assign bankOn = (seg % 2 == 0) ? modIf.bankOdd :
				modIf.bankEven;
			assign blinkOk = (seg != 0) || !firstEmptyFlag ||
				modIf.blinkPhase;
			assign next_leds[seg] = displayOn && lit && bankOn && blinkOk;
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			ledDriveLines <= 5'h00;
		else
			ledDriveLines <= next_leds;
	end

	chk_request_high_off: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		reqHigh && !reqFloat |=> ledDriveLines == 5'h00)
		else $error("segments active with request high");
	chk_final_empty_off: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		finalEmptyFlag |=> ledDriveLines == 5'h00)
		else $error("segments active at final empty");
	chk_bank_groups: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		(ledDriveLines[1] || ledDriveLines[3]) |->
		!(ledDriveLines[0] || ledDriveLines[2] || ledDriveLines[4]))
		else $error("segment banks overlap");
	chk_soft_reset_load: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		softReset |=> availableChargeCount == 8'h00 &&
		learnedFullCapacity == $past(programmedFullCount) &&
		learnStaleFlag && batteryReplacedFlag &&
		filterSetting == GLD_FILTER_RESET)
		else $error("soft reset defaults not loaded");
	chk_filter_write: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		regWrite && regAddr == GLD_ADDR_FILTER |=>
		filterSetting == $past(regWrData))
		else $error("filter register not written");
	chk_selfdis_hold: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		selfDisOff && selfDischargeTick && !chargeTick && !dischargeTick &&
		!regWrite && !softReset && !initLoad |=> $stable(nacWord))
		else $error("self-discharge counted while disabled");
	cov_soft_reset: cover property (
		@(posedge ref_clk) disable iff (!reset_n) softReset);
	cov_blink_low: cover property (
		@(posedge ref_clk) disable iff (!reset_n)
		firstEmptyFlag && $fell(modIf.blinkPhase));
	cov_float_show: cover property (
		@(posedge ref_clk) disable iff (!reset_n)
		reqFloat && ledDriveLines != 5'h00);

endmodule : gld_display_top

// >>> rtl/gld_pkg.sv
// constants and types shared by the gauge display and soft reset block
package gld_pkg;

	// register offsets
	localparam logic [7:0] GLD_ADDR_NACH = 8'h03;
	localparam logic [7:0] GLD_ADDR_LFC = 8'h05;
	localparam logic [7:0] GLD_ADDR_CIC = 8'h09;
	localparam logic [7:0] GLD_ADDR_FILTER = 8'h0A;
	localparam logic [7:0] GLD_ADDR_AVAILABLE_CHARGE_LOW = 8'h17;
	localparam logic [7:0] GLD_ADDR_SWRST = 8'h39;

	// soft reset trigger values
	localparam logic [7:0] GLD_SWRST_IDLE = 8'h00;
	localparam logic [7:0] GLD_SWRST_FIRE = 8'h80;

	// filter layout: [3:0] charge step count, [7:4] discharge step count
	localparam int GLD_FLT_CHG_LSB = 0;
	localparam int GLD_FLT_DSG_LSB = 4;
	localparam logic [7:0] GLD_FILTER_RESET = 8'h45;
	localparam logic signed [16:0] GLD_THR_STEP_UV = 17'sh0004B;
	// -4 mV display activation level
	localparam logic signed [16:0] GLD_SHOW_LEVEL_REQUEST_N_DSG_UV = 17'sh1F060;

	// values after reset
	localparam logic [7:0] GLD_CIC_RESET = 8'h00;
	localparam logic [7:0] GLD_NAC_RESET = 8'h00;
	localparam logic GLD_VDQ_RESET = 1'b0;
	localparam logic GLD_STALE_RESET = 1'b1;
	localparam logic GLD_REPL_RESET = 1'b1;

	// timing
	localparam int GLD_CLK_PERIOD_NS = 100;
	localparam int GLD_MOD_RATE_HZ = 100;
	localparam int GLD_BANK_ON_PCT = 30;
	localparam int GLD_BLINK_RATE_HZ = 4;
	localparam int GLD_MOD_CYCLES =
		1_000_000_000 / (GLD_MOD_RATE_HZ * GLD_CLK_PERIOD_NS);
	localparam int GLD_BLINK_HALF_CYCLES =
		1_000_000_000 / (2 * GLD_BLINK_RATE_HZ * GLD_CLK_PERIOD_NS);

	// temperature code limits of the derating steps
	localparam logic [3:0] GLD_TC_COLD_MAX = 4'h1;
	localparam logic [3:0] GLD_TC_COOL_MAX = 4'h3;
	localparam logic [3:0] GLD_TC_COLD_EXIT = 4'h3;
	localparam logic [3:0] GLD_TC_COOL_EXIT = 4'h5;

	localparam int GLD_NUM_SEG = 5;

	typedef enum logic [2:0]
	{
		GLD_DR_FULL = 3'b001,
		GLD_DR_COOL = 3'b010,
		GLD_DR_COLD = 3'b100
	} gld_derate_t;

endpackage : gld_pkg

// >>> rtl/gld_mod_if.sv
// bank modulation and blink phase between the timing module and the top
`timescale 1ns/100ps
interface gld_mod_if;
	logic bankOdd;
	logic bankEven;
	logic blinkPhase;
	modport source (output bankOdd, output bankEven, output blinkPhase);
	modport sink (input bankOdd, input bankEven, input blinkPhase);
endinterface : gld_mod_if

// >>> rtl/gld_led_modulator.sv
// two-bank led modulation timing and low battery blink phase
`timescale 1ns/100ps
module gld_led_modulator
	import gld_pkg::*;
#(
	parameter int MOD_CYCLES = GLD_MOD_CYCLES,
	parameter int BLINK_HALF_CYCLES = GLD_BLINK_HALF_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	gld_mod_if.source modIf
);
	localparam int BANK_ON = MOD_CYCLES * GLD_BANK_ON_PCT / 100;
	localparam int BANK_B_START = MOD_CYCLES / 2;

	logic [31:0] phase;
	logic [31:0] next_phase;
	logic [31:0] blinkCnt;
	logic [31:0] next_blinkCnt;
	logic blinkPhase;
	logic next_blinkPhase;

	always_comb
	begin
		next_phase = phase + 32'h00000001;
		if (phase == 32'(MOD_CYCLES - 1))
			next_phase = 32'h00000000;
		next_blinkCnt = blinkCnt + 32'h00000001;
		next_blinkPhase = blinkPhase;
		if (blinkCnt == 32'(BLINK_HALF_CYCLES - 1))
		begin
			next_blinkCnt = 32'h00000000;
			next_blinkPhase = ~blinkPhase;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase <= 32'h00000000;
			blinkCnt <= 32'h00000000;
			blinkPhase <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			blinkCnt <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
		end
	end

	// banks sit in opposite halves with a dead gap after each
	assign modIf.bankOdd = (phase < 32'(BANK_ON));
	assign modIf.bankEven = (phase >= 32'(BANK_B_START)) &&
		(phase < 32'(BANK_B_START + BANK_ON));
	assign modIf.blinkPhase = blinkPhase;

	int oddRun;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			oddRun <= 0;
		else if (modIf.bankOdd)
			oddRun <= oddRun + 1;
		else
			oddRun <= 0;
	end

	chk_banks_exclusive: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		!(modIf.bankOdd && modIf.bankEven))
		else $error("both led banks enabled together");

	chk_bank_duty: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$fell(modIf.bankOdd) |-> $past(oddRun) == BANK_ON - 1)
		else $error("odd bank on time differs from duty");

	chk_period_wrap: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		phase == 32'(MOD_CYCLES - 1) |=> phase == 32'h00000000 ##1
		phase == 32'h00000001)
		else $error("modulation period wrap wrong");

	chk_blink_rate: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$changed(blinkPhase) |->
		$past(blinkCnt) == 32'(BLINK_HALF_CYCLES - 1))
		else $error("blink toggle off its half period");

	cov_even_bank: cover property (
		@(posedge ref_clk) disable iff (!reset_n) $rose(modIf.bankEven));

endmodule : gld_led_modulator

// >>> testbench/gld_led_panel.sv
// led panel model: bank activity of the segment lines per window
`timescale 1ns/100ps
module gld_led_panel
(
	input wire logic ref_clk,
	input wire logic clr,
	input wire logic en,
	input wire logic [4:0] ledDriveLines,
	output logic [4:0] litMask,
	output int oddCnt,
	output int evenCnt,
	output int overlapCnt
);
	always @(posedge ref_clk)
	begin
		if (clr)
		begin
			litMask <= 5'h00;
			oddCnt <= 0;
			evenCnt <= 0;
			overlapCnt <= 0;
		end
		else if (en)
		begin
			litMask <= litMask | ledDriveLines;
			oddCnt <= oddCnt + int'(|{ledDriveLines[0], ledDriveLines[2],
				ledDriveLines[4]});
			evenCnt <= evenCnt + int'(|{ledDriveLines[1], ledDriveLines[3]});
			overlapCnt <= overlapCnt + int'(|{ledDriveLines[0],
				ledDriveLines[2], ledDriveLines[4]} &&
				|{ledDriveLines[1], ledDriveLines[3]});
		end
	end
endmodule : gld_led_panel

// >>> testbench/gauge_led_display_and_soft_reset_tb.sv
// self-checking bench for the gauge display and soft reset block
`timescale 1ns/100ps
module gauge_led_display_and_soft_reset_tb
	import gld_pkg::*;
;
	localparam int MODC = 20;
	localparam int ONC = MODC * GLD_BANK_ON_PCT / 100;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic reqN = 1'b1;
	logic flt = 1'b0;
	logic sdOpt = 1'b0;
	logic firstEmpty = 1'b0;
	logic finalEmpty = 1'b0;
	logic signed [15:0] sense = 16'sh0000;
	logic [3:0] tempCode = 4'h6;
	logic sdTick = 1'b0;
	logic chgTick = 1'b0;
	logic dsgTick = 1'b0;
	logic [7:0] programmed_full_count = 8'h64;
	logic clr = 1'b0;
	logic en = 1'b0;
	logic [7:0] regRdData, lfc, nacH, available_charge_low, cic, d;
	logic [4:0] leds, litMask;
	logic valid_discharge_qualifier, stale, repl, vChg, vDsg;
	int oddCnt, evenCnt, overlapCnt, c, dd, n, on;
	int error_cnt = 0;
	int compares = 0;
	logic [15:0] w;

	gld_display_top #(.MOD_CYCLES(MODC), .BLINK_HALF_CYCLES(80)) u_dut
	(
		.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .showLevelRequestN(reqN),
		.showLevelFloat(flt), .selfDischargeOptionPin(sdOpt),
		.firstEmptyFlag(firstEmpty), .finalEmptyFlag(finalEmpty),
		.senseLevelUv(sense), .tempCode(tempCode), .chargeTick(chgTick),
		.dischargeTick(dsgTick), .selfDischargeTick(sdTick),
		.programmedFullCount(programmed_full_count), .ledDriveLines(leds),
		.learnedFullCapacity(lfc), .availableChargeCount(nacH),
		.availableChargeLow(available_charge_low), .capacityInaccurateCount(cic),
		.validDischargeQualifier(valid_discharge_qualifier), .learnStaleFlag(stale),
		.batteryReplacedFlag(repl), .validCharge(vChg),
		.validDischarge(vDsg)
	);
	gld_led_panel u_panel
	(
		.ref_clk(ref_clk), .clr(clr), .en(en), .ledDriveLines(leds),
		.litMask(litMask), .oddCnt(oddCnt), .evenCnt(evenCnt),
		.overlapCnt(overlapCnt)
	);

	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(posedge ref_clk);
		d = regRdData;
	endtask : rd

	task automatic sn(input int s);
		sense <= 16'(s);
		repeat (4) @(posedge ref_clk);
	endtask : sn

	// one modulation period seen by the panel, after pin sync settles
	task automatic watch();
		repeat (6) @(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		en <= 1'b1;
		repeat (MODC) @(posedge ref_clk);
		en <= 1'b0;
		@(posedge ref_clk);
	endtask : watch

	function automatic logic [4:0] segs(input int available_charge_count, input int t);
		int s;
		logic [4:0] m;
		s = (t <= 1) ? available_charge_count / 2 : (t <= 3) ? available_charge_count - available_charge_count / 4 : available_charge_count;
		m = 5'h00;
		for (int i = 1; i <= 5; i++)
			if (s != 0 && s * 5 >= i * int'(programmed_full_count))
				m[i-1] = 1'b1;
		return m;
	endfunction : segs

	task automatic show_level_request_n(input logic [4:0] m);
		watch();
		chk(16'(litMask), 16'(m));
		chk(16'(oddCnt), (m[0] | m[2] | m[4]) ? 16'(ONC) : 16'h0000);
		chk(16'(evenCnt), (m[1] | m[3]) ? 16'(ONC) : 16'h0000);
		chk(16'(overlapCnt), 16'h0000);
	endtask : show_level_request_n

	initial
	begin
		#(20000 * 100);
		error_cnt++;
		end_sim();
	end

	initial
	begin
		void'($urandom(32'h898D7B3B));
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(16'(lfc), 16'(programmed_full_count));
		chk({nacH, available_charge_low}, 16'h0000);
		chk({cic, 5'h00, valid_discharge_qualifier, stale, repl}, 16'h0003);
		rd(GLD_ADDR_FILTER);
		chk(16'(d), 16'h0045);
		rd(8'h20);
		chk(16'(d), 16'h0000);
		sn(375);
		chk(16'(vChg), 16'h0001);
		sn(374);
		chk(16'(vChg), 16'h0000);
		sn(-300);
		chk(16'(vDsg), 16'h0001);
		sn(-299);
		chk(16'(vDsg), 16'h0000);
		repeat (4)
		begin
			c = 2 + $urandom % 14;
			dd = 2 + $urandom % 14;
			wr(GLD_ADDR_FILTER, 8'(dd * 16 + c));
			rd(GLD_ADDR_FILTER);
			chk(16'(d), 16'(dd * 16 + c));
			sn(c * 75);
			chk(16'(vChg), 16'h0001);
			sn(c * 75 - 1);
			chk(16'(vChg), 16'h0000);
			sn(-dd * 75);
			chk(16'(vDsg), 16'h0001);
			sn(-dd * 75 + 1);
			chk(16'(vDsg), 16'h0000);
		end
		programmed_full_count <= 8'(40 + $urandom % 200);
		wr(GLD_ADDR_NACH, 8'h20);
		wr(GLD_ADDR_SWRST, GLD_SWRST_FIRE);
		@(posedge ref_clk);
		chk(16'(lfc), 16'(programmed_full_count));
		chk(16'(nacH), 16'h0000);
		chk({cic, available_charge_low}, 16'h0000);
		chk(16'({valid_discharge_qualifier, stale, repl}), 16'h0003);
		rd(GLD_ADDR_FILTER);
		chk(16'(d), 16'h0045);
		rd(GLD_ADDR_SWRST);
		chk(16'(d), 16'h0000);
		wr(GLD_ADDR_NACH, 8'h10);
		sdOpt <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			repeat (4) @(posedge ref_clk);
			w = {nacH, available_charge_low};
			sdTick <= 1'b1;
			@(posedge ref_clk);
			sdTick <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(16'({nacH, available_charge_low} < w), 16'(k));
			sdOpt <= 1'b0;
		end
		w = {nacH, available_charge_low};
		chgTick <= 1'b1;
		@(posedge ref_clk);
		chgTick <= 1'b0;
		@(posedge ref_clk);
		chk({nacH, available_charge_low}, w + 16'h0001);
		dsgTick <= 1'b1;
		@(posedge ref_clk);
		dsgTick <= 1'b0;
		@(posedge ref_clk);
		chk({nacH, available_charge_low}, w);
		reqN <= 1'b0;
		for (int t = 0; t < 4; t++)
		begin
			tempCode <= 4'(t == 1 ? 2 : t == 2 ? 0 : 6);
			for (int k = 0; k < 3; k++)
			begin
				n = k == 0 ? int'(programmed_full_count) : k == 1 ? 0 : ($urandom % (programmed_full_count + 1)) & ~3;
				wr(GLD_ADDR_NACH, 8'(n));
				show_level_request_n(segs(n, t == 1 ? 2 : t == 2 ? 0 : 6));
				chk(16'(nacH), 16'(n));
			end
		end
		wr(GLD_ADDR_NACH, programmed_full_count);
		reqN <= 1'b1;
		show_level_request_n(5'h00);
		reqN <= 1'b0;
		finalEmpty <= 1'b1;
		show_level_request_n(5'h00);
		finalEmpty <= 1'b0;
		flt <= 1'b1;
		reqN <= 1'b1;
		sn(-5000);
		show_level_request_n(5'h1F);
		sn(0);
		show_level_request_n(5'h00);
		sn(500);
		show_level_request_n(5'h1F);
		flt <= 1'b0;
		reqN <= 1'b0;
		firstEmpty <= 1'b1;
		on = 0;
		repeat (7)
		begin
			watch();
			on += int'(litMask[0]);
			chk(16'(litMask[4]), 16'h0001);
		end
		chk(16'(on > 0 && on < 7), 16'h0001);
		end_sim();
	end
endmodule : gauge_led_display_and_soft_reset_tb
